/* File: logic/phybc_defines.svh */
// Constants for the transceiver basic control register bank
`ifndef PHYBC_DEFINES_SVH
`define PHYBC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PHYBC_IDX_W 5
`define PHYBC_DATA_W 16
`define PHYBC_CNT_W 4

// ----------------------------------------------------------------
// Register indexes (decimal in the register map)
// ----------------------------------------------------------------
`define PHYBC_IDX_BASIC_CTRL 5'h00
`define PHYBC_IDX_BASIC_STAT 5'h01
`define PHYBC_IDX_ID1 5'h02
`define PHYBC_IDX_ID2 5'h03
`define PHYBC_IDX_AN_ADV 5'h04
`define PHYBC_IDX_AN_LPA 5'h05
`define PHYBC_IDX_AN_EXP 5'h06
`define PHYBC_IDX_MODE_CS 5'h11
`define PHYBC_IDX_SPEC_MODES 5'h12
`define PHYBC_IDX_SPEC_IND 5'h1b
`define PHYBC_IDX_INT_SRC 5'h1d
`define PHYBC_IDX_INT_MASK 5'h1e
`define PHYBC_IDX_SPEC_CS 5'h1f

// ----------------------------------------------------------------
// Basic control and status field positions
// ----------------------------------------------------------------
`define PHYBC_BIT_SOFT_RESET 15
`define PHYBC_BIT_LOOPBACK 14
`define PHYBC_BIT_SPEED 13
`define PHYBC_BIT_AN_ENABLE 12
`define PHYBC_BIT_POWER_DOWN 11
`define PHYBC_BIT_AN_RESTART 9
`define PHYBC_BIT_DUPLEX 8
`define PHYBC_BIT_COL_TEST 7
`define PHYBC_BIT_AN_DONE 5

// Bits held in storage, reserved bits, and bits kept over a soft reset
`define PHYBC_CTRL_STORE_MASK 16'h7980
`define PHYBC_CTRL_RSVD_MASK 16'h047f
`define PHYBC_SOFT_RESET_IMMUNE_MASK 16'h0000

// ----------------------------------------------------------------
// Reset values (speed and negotiation enable come from the strap)
// ----------------------------------------------------------------
`define PHYBC_CTRL_RST_FIXED 16'h0000
`define PHYBC_STAT_RST 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PHYBC_CLK_PERIOD_NS 50
`define PHYBC_SOFT_RESET_TIME_NS 500
`define PHYBC_SOFT_RESET_CYCLES \
   ((`PHYBC_SOFT_RESET_TIME_NS + `PHYBC_CLK_PERIOD_NS - 1) / `PHYBC_CLK_PERIOD_NS)
`define PHYBC_STRAP_WAIT 2

`endif

/* File: logic/phybc_pkg.sv */
// Types for the transceiver basic control register bank
package phybc_pkg;

   // Gray along load -> run -> soft reset -> run
   typedef enum logic [1:0] {
      st_load = 2'h0,
      st_run = 2'h1,
      st_srst = 2'h3
   } phybc_state_t;

endpackage

/* File: logic/phybc_sync2.sv */
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module phybc_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Level in and out
   input wire logic async_in,
   output logic sync_out
);

   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

/* File: logic/phybc_idx_decode.sv */
// Register index decoder for the transceiver register set
`timescale 1ns/1ns
`include "phybc_defines.svh"
module phybc_idx_decode (
   // Index in
   input wire logic [`PHYBC_IDX_W-1:0] idx,
   // Decode out
   output logic hit,
   output logic is_ctrl,
   output logic is_stat
);

   // ----------------------------------------------------------------
   // Decoded index set
   // ----------------------------------------------------------------
   logic low_group;
   logic high_group;

   assign low_group = (idx <= `PHYBC_IDX_AN_EXP);
   assign high_group = (idx == `PHYBC_IDX_MODE_CS) ||
                       (idx == `PHYBC_IDX_SPEC_MODES) ||
                       (idx == `PHYBC_IDX_SPEC_IND) ||
                       (idx == `PHYBC_IDX_INT_SRC) ||
                       (idx == `PHYBC_IDX_INT_MASK) ||
                       (idx == `PHYBC_IDX_SPEC_CS);
   assign hit = low_group | high_group;
   assign is_ctrl = (idx == `PHYBC_IDX_BASIC_CTRL);
   assign is_stat = (idx == `PHYBC_IDX_BASIC_STAT);

endmodule

/* File: logic/phybc_regs.sv */
// Transceiver management register bank with the basic control register
//
// Operation
// - The registers have no memory address and are reached by index through access and data.
// - Indexes 0 to 6, 17, 18, 27, 29, 30 and 31 are recognised by the decoder.
// - No field is marked immune to soft reset; a soft reset reloads every stored bit to its default.
// - Writing 1 to bit 15 starts a soft reset and the bit then clears by itself.
// - Bit 14 selects loopback when 1, normal when 0, and resets to 0.
// - Bit 13 selects 100Mbps when 1, 10Mbps when 0, and is ignored while negotiation is on.
// - Bit 12 enables negotiation, whose results then override bits 13 and 8.
// - Bits 13 and 12 reset to the level of the speed strap, not to a constant.
// - Bit 11 powers the transceiver down; after clearing it, status bit 5 sets on completion.
// - Writing 1 to bit 9 restarts negotiation; the bit clears itself and reads 0.
// - Bit 8 selects full duplex when 1, half when 0, resets to 0, ignored under negotiation.
// - Bit 7 enables the collision test when 1 and resets to 0.
`timescale 1ns/1ns
`include "phybc_defines.svh"
module phybc_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Indexed management access
   input wire logic mgmt_wr_strobe,
   input wire logic mgmt_rd_strobe,
   input wire logic [`PHYBC_IDX_W-1:0] mgmt_index,
   input wire logic [`PHYBC_DATA_W-1:0] mgmt_wr_data,
   output logic [`PHYBC_DATA_W-1:0] mgmt_rd_data,
   output logic mgmt_rd_valid,
   output logic mgmt_rd_hit,
   // Speed strap pin
   input wire logic speed_sel_strap,
   // Negotiation results from the transceiver core
   input wire logic an_complete,
   input wire logic an_result_speed_100,
   input wire logic an_result_full_duplex,
   // Controls to the transceiver core
   output logic soft_reset_active,
   output logic loopback_en,
   output logic power_down,
   output logic an_enable,
   output logic an_restart,
   output logic speed_100,
   output logic full_duplex,
   output logic col_test_en
);

   // ----------------------------------------------------------------
   // Strap synchroniser and index decode
   // ----------------------------------------------------------------
   logic strap_sync;
   logic idx_hit;
   logic idx_ctrl;
   logic idx_stat;

   phybc_sync2 #(
      .RST_VAL(1'b0)
   ) u_strap_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .async_in(speed_sel_strap),
      .sync_out(strap_sync)
   );

   phybc_idx_decode u_idx_decode (
      .idx(mgmt_index),
      .hit(idx_hit),
      .is_ctrl(idx_ctrl),
      .is_stat(idx_stat)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   phybc_pkg::phybc_state_t state_reg;
   phybc_pkg::phybc_state_t state_next;
   logic [`PHYBC_CNT_W-1:0] cnt_reg;
   logic [`PHYBC_CNT_W-1:0] cnt_next;
   logic [`PHYBC_DATA_W-1:0] ctrl_reg;
   logic [`PHYBC_DATA_W-1:0] ctrl_next;
   logic srst_active_reg;
   logic an_done_reg;
   logic an_done_next;
   logic an_restart_reg;
   logic loopback_reg;
   logic power_down_reg;
   logic an_enable_reg;
   logic speed_reg;
   logic duplex_reg;
   logic col_test_reg;
   logic [`PHYBC_DATA_W-1:0] rd_data_reg;
   logic rd_valid_reg;
   logic rd_hit_reg;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic in_run;
   logic ctrl_wr;
   logic srst_req;
   logic ctrl_ld;
   logic restart_req;
   logic strap_load;
   logic srst_done;

   assign in_run = (state_reg == phybc_pkg::st_run);
   assign ctrl_wr = mgmt_wr_strobe & idx_ctrl & in_run;
   assign srst_req = ctrl_wr & mgmt_wr_data[`PHYBC_BIT_SOFT_RESET];
   // A soft reset write drops the other bits of the same word
   assign ctrl_ld = ctrl_wr & ~srst_req;
   assign restart_req = ctrl_ld & mgmt_wr_data[`PHYBC_BIT_AN_RESTART];
   assign strap_load = (state_reg == phybc_pkg::st_load) &&
                       (cnt_reg == `PHYBC_CNT_W'(`PHYBC_STRAP_WAIT));
   assign srst_done = (state_reg == phybc_pkg::st_srst) &&
                      (cnt_reg == `PHYBC_CNT_W'(`PHYBC_SOFT_RESET_CYCLES - 1));

   // ----------------------------------------------------------------
   // Control word next value
   // ----------------------------------------------------------------
   logic [`PHYBC_DATA_W-1:0] ctrl_dflt;
   logic [`PHYBC_DATA_W-1:0] ctrl_after_srst;
   logic [`PHYBC_DATA_W-1:0] ctrl_written;

   // Speed and negotiation enable follow the strap level
   assign ctrl_dflt = `PHYBC_CTRL_RST_FIXED |
                      {2'h0, strap_sync, strap_sync, 12'h000};
   assign ctrl_after_srst = (ctrl_reg & `PHYBC_SOFT_RESET_IMMUNE_MASK) |
                            (ctrl_dflt & ~`PHYBC_SOFT_RESET_IMMUNE_MASK);
   assign ctrl_written = mgmt_wr_data & `PHYBC_CTRL_STORE_MASK;
   assign ctrl_next = ctrl_ld ? ctrl_written : srst_req ? ctrl_after_srst :
                      strap_load ? ctrl_dflt : ctrl_reg;

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         phybc_pkg::st_load: begin
            if (strap_load) begin
               state_next = phybc_pkg::st_run;
               cnt_next = `PHYBC_CNT_W'(0);
            end else begin
               cnt_next = cnt_reg + `PHYBC_CNT_W'(1);
            end
         end
         phybc_pkg::st_run: begin
            if (srst_req) begin
               state_next = phybc_pkg::st_srst;
               cnt_next = `PHYBC_CNT_W'(0);
            end
         end
         phybc_pkg::st_srst: begin
            if (srst_done) begin
               state_next = phybc_pkg::st_run;
               cnt_next = `PHYBC_CNT_W'(0);
            end else begin
               cnt_next = cnt_reg + `PHYBC_CNT_W'(1);
            end
         end
         default: begin
            state_next = phybc_pkg::st_load;
            cnt_next = `PHYBC_CNT_W'(0);
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Negotiation complete status
   // ----------------------------------------------------------------
   logic an_done_set;
   logic an_done_clr;

   // Completion is held off while powered down; a set beats a clear
   assign an_done_set = an_complete & ~ctrl_reg[`PHYBC_BIT_POWER_DOWN];
   assign an_done_clr = ctrl_reg[`PHYBC_BIT_POWER_DOWN] | an_restart_reg | srst_active_reg;
   assign an_done_next = an_done_set | (an_done_reg & ~an_done_clr);

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [`PHYBC_DATA_W-1:0] ctrl_read;
   logic [`PHYBC_DATA_W-1:0] stat_read;
   logic [`PHYBC_DATA_W-1:0] rd_word;

   // Restart reads 0 since it is never stored; reset reads 1 while it runs
   assign ctrl_read = ctrl_reg | {srst_active_reg, 15'h0000};
   assign stat_read = `PHYBC_STAT_RST | {10'h000, an_done_reg, 5'h00};
   assign rd_word = idx_ctrl ? ctrl_read : idx_stat ? stat_read : 16'h0000;

   // ----------------------------------------------------------------
   // Effective modes
   // ----------------------------------------------------------------
   logic eff_speed;
   logic eff_duplex;

   assign eff_speed = ctrl_reg[`PHYBC_BIT_AN_ENABLE] ? an_result_speed_100 :
                      ctrl_reg[`PHYBC_BIT_SPEED];
   assign eff_duplex = ctrl_reg[`PHYBC_BIT_AN_ENABLE] ? an_result_full_duplex :
                       ctrl_reg[`PHYBC_BIT_DUPLEX];

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= phybc_pkg::st_load;
         cnt_reg <= `PHYBC_CNT_W'(0);
         ctrl_reg <= `PHYBC_CTRL_RST_FIXED;
         srst_active_reg <= 1'b0;
         an_done_reg <= 1'b0;
         an_restart_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ctrl_reg <= ctrl_next;
         srst_active_reg <= (state_next == phybc_pkg::st_srst);
         an_done_reg <= an_done_next;
         an_restart_reg <= restart_req;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         loopback_reg <= 1'b0;
         power_down_reg <= 1'b0;
         an_enable_reg <= 1'b0;
         speed_reg <= 1'b0;
         duplex_reg <= 1'b0;
         col_test_reg <= 1'b0;
      end else begin
         loopback_reg <= ctrl_reg[`PHYBC_BIT_LOOPBACK];
         power_down_reg <= ctrl_reg[`PHYBC_BIT_POWER_DOWN];
         an_enable_reg <= ctrl_reg[`PHYBC_BIT_AN_ENABLE];
         speed_reg <= eff_speed;
         duplex_reg <= eff_duplex;
         col_test_reg <= ctrl_reg[`PHYBC_BIT_COL_TEST];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_data_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
         rd_hit_reg <= 1'b0;
      end else begin
         rd_data_reg <= mgmt_rd_strobe ? rd_word : rd_data_reg;
         rd_valid_reg <= mgmt_rd_strobe;
         rd_hit_reg <= mgmt_rd_strobe ? idx_hit : rd_hit_reg;
      end
   end

   assign mgmt_rd_data = rd_data_reg;
   assign mgmt_rd_valid = rd_valid_reg;
   assign mgmt_rd_hit = rd_hit_reg;
   assign soft_reset_active = srst_active_reg;
   assign loopback_en = loopback_reg;
   assign power_down = power_down_reg;
   assign an_enable = an_enable_reg;
   assign an_restart = an_restart_reg;
   assign speed_100 = speed_reg;
   assign full_duplex = duplex_reg;
   assign col_test_en = col_test_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence srst_window_s;
      soft_reset_active [*8] ##1 soft_reset_active ##1 soft_reset_active;
   endsequence
   sequence srst_end_s;
      ##1 !soft_reset_active;
   endsequence

   srst_self_clear_a: assert property (srst_req |=> srst_window_s ##0 srst_end_s)
      else $error("soft reset did not last its count or did not self clear");

   srst_reload_a: assert property (srst_req |=>
      ((ctrl_reg & ~`PHYBC_SOFT_RESET_IMMUNE_MASK) ==
       ($past(ctrl_dflt) & ~`PHYBC_SOFT_RESET_IMMUNE_MASK)) &&
      ((ctrl_reg & `PHYBC_SOFT_RESET_IMMUNE_MASK) ==
       ($past(ctrl_reg) & `PHYBC_SOFT_RESET_IMMUNE_MASK)))
      else $error("soft reset did not reload control defaults");

   srst_bit_read_a: assert property (mgmt_rd_strobe && idx_ctrl && soft_reset_active |=>
      mgmt_rd_valid && mgmt_rd_data[`PHYBC_BIT_SOFT_RESET])
      else $error("reset bit not read as one during soft reset");

   restart_pulse_a: assert property (restart_req ##1 !restart_req |->
      an_restart ##1 !an_restart)
      else $error("restart not a single pulse");

   ctrl_rsvd_zero_a: assert property (mgmt_rd_strobe && idx_ctrl |=>
      ((mgmt_rd_data & `PHYBC_CTRL_RSVD_MASK) == 16'h0000) &&
      !mgmt_rd_data[`PHYBC_BIT_AN_RESTART])
      else $error("reserved or restart bit read nonzero");

   unmapped_read_a: assert property (mgmt_rd_strobe && !idx_hit |=>
      mgmt_rd_valid && !mgmt_rd_hit && (mgmt_rd_data == 16'h0000))
      else $error("undecoded index read not zero");

   unmapped_write_a: assert property (mgmt_wr_strobe && !idx_hit && !strap_load |=>
      $stable(ctrl_reg))
      else $error("undecoded index write changed control");

   ctrl_apply_a: assert property (ctrl_ld |-> ##2
      (loopback_en == $past(mgmt_wr_data[`PHYBC_BIT_LOOPBACK], 2)) &&
      (power_down == $past(mgmt_wr_data[`PHYBC_BIT_POWER_DOWN], 2)) &&
      (col_test_en == $past(mgmt_wr_data[`PHYBC_BIT_COL_TEST], 2)))
      else $error("written mode bit did not reach its output");

   manual_mode_a: assert property (ctrl_ld && !mgmt_wr_data[`PHYBC_BIT_AN_ENABLE] |-> ##2
      (speed_100 == $past(mgmt_wr_data[`PHYBC_BIT_SPEED], 2)) &&
      (full_duplex == $past(mgmt_wr_data[`PHYBC_BIT_DUPLEX], 2)))
      else $error("manual speed or duplex not applied");

   an_override_a: assert property (ctrl_ld && mgmt_wr_data[`PHYBC_BIT_AN_ENABLE] ##1 1 |=>
      an_enable && (speed_100 == $past(an_result_speed_100)) &&
      (full_duplex == $past(an_result_full_duplex)))
      else $error("negotiation result did not override manual bits");

   strap_default_a: assert property (strap_load |=>
      (ctrl_reg[`PHYBC_BIT_SPEED] == $past(strap_sync)) &&
      (ctrl_reg[`PHYBC_BIT_AN_ENABLE] == $past(strap_sync)))
      else $error("speed or negotiation default not taken from strap");

   pdown_status_a: assert property (ctrl_reg[`PHYBC_BIT_POWER_DOWN] |=> !an_done_reg)
      else $error("completion status set while powered down");

   an_done_set_a: assert property (an_complete && !ctrl_reg[`PHYBC_BIT_POWER_DOWN] |=>
      an_done_reg)
      else $error("completion status not set");

endmodule

/* File: sim/phybc_regs_test.sv */
// Self-checking bench for the transceiver basic control register bank
`timescale 1ns/1ns
`include "phybc_defines.svh"
module phybc_regs_test;
   // ----------------------------------------------------------------
   // Stimulus and bookkeeping
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic mgmt_wr_strobe = 1'b0;
   logic mgmt_rd_strobe = 1'b0;
   logic [`PHYBC_IDX_W-1:0] mgmt_index = 5'h00;
   logic [`PHYBC_DATA_W-1:0] mgmt_wr_data = 16'h0000;
   logic [`PHYBC_DATA_W-1:0] mgmt_rd_data;
   logic mgmt_rd_valid, mgmt_rd_hit;
   logic speed_sel_strap = 1'b0;
   logic an_complete = 1'b0;
   logic an_result_speed_100 = 1'b0;
   logic an_result_full_duplex = 1'b0;
   logic soft_reset_active, loopback_en, power_down, an_enable;
   logic an_restart, speed_100, full_duplex, col_test_en;
   logic [15:0] exp_d[$];
   logic exp_h[$];
   logic [15:0] ctrl_exp = 16'h0000;
   logic [15:0] dflt = 16'h0000;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 78357;
   int restart_cnt = 0;
   int srst_cnt = 0;

   always #25 ref_clk = ~ref_clk;

   phybc_regs dut_u (
      .ref_clk(ref_clk), .reset(reset),
      .mgmt_wr_strobe(mgmt_wr_strobe), .mgmt_rd_strobe(mgmt_rd_strobe),
      .mgmt_index(mgmt_index), .mgmt_wr_data(mgmt_wr_data),
      .mgmt_rd_data(mgmt_rd_data), .mgmt_rd_valid(mgmt_rd_valid), .mgmt_rd_hit(mgmt_rd_hit),
      .speed_sel_strap(speed_sel_strap), .an_complete(an_complete),
      .an_result_speed_100(an_result_speed_100),
      .an_result_full_duplex(an_result_full_duplex),
      .soft_reset_active(soft_reset_active), .loopback_en(loopback_en),
      .power_down(power_down), .an_enable(an_enable), .an_restart(an_restart),
      .speed_100(speed_100), .full_duplex(full_duplex), .col_test_en(col_test_en)
   );

   // Pulse and soft reset cycle counters
   always @(posedge ref_clk) begin
      if (an_restart === 1'b1) restart_cnt <= restart_cnt + 1;
      if (soft_reset_active === 1'b1) srst_cnt <= srst_cnt + 1;
   end

   // ----------------------------------------------------------------
   // Compare and access tasks
   // ----------------------------------------------------------------
   task automatic chk_rd(input logic [15:0] gd, input logic gh, input logic [15:0] ed,
                         input logic eh);
      tests_run++;
      if (gd !== ed || gh !== eh) begin
         fail_count++;
         $display("[FAIL] %0t read got %h/%b expected %h/%b", $time, gd, gh, ed, eh);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp, input string what);
      tests_run++;
      if (got != exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      mgmt_wr_strobe = 1'b0;
      mgmt_rd_strobe = 1'b0;
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic do_wr(input logic [4:0] idx, input logic [15:0] data);
      mgmt_rd_strobe = 1'b0;
      mgmt_wr_strobe = 1'b1;
      mgmt_index = idx;
      mgmt_wr_data = data;
      @(negedge ref_clk);
   endtask

   task automatic do_rd(input logic [4:0] idx, input logic [15:0] ed, input logic eh);
      mgmt_wr_strobe = 1'b0;
      mgmt_rd_strobe = 1'b1;
      mgmt_index = idx;
      exp_d.push_back(ed);
      exp_h.push_back(eh);
      @(negedge ref_clk);
   endtask

   task automatic pulse_done();
      an_complete = 1'b1;
      @(negedge ref_clk);
      an_complete = 1'b0;
   endtask

   task automatic do_reset(input logic s);
      reset = 1'b1;
      speed_sel_strap = s;
      idle(3);
      reset = 1'b0;
      idle(6);
      dflt = s ? 16'h3000 : 16'h0000;
      ctrl_exp = dflt;
   endtask

   task automatic check_outs();
      logic s, f;
      s = ctrl_exp[12] ? an_result_speed_100 : ctrl_exp[13];
      f = ctrl_exp[12] ? an_result_full_duplex : ctrl_exp[8];
      chk_bit(loopback_en, ctrl_exp[14], "loopback");
      chk_bit(an_enable, ctrl_exp[12], "negotiation enable");
      chk_bit(speed_100, s, "speed");
      chk_bit(full_duplex, f, "duplex");
      chk_bit(power_down, ctrl_exp[11], "power down");
      chk_bit(col_test_en, ctrl_exp[7], "collision test");
      chk_bit(soft_reset_active, 1'b0, "soft reset idle");
   endtask

   function automatic logic is_dec(input int i);
      return i <= 6 || i == 17 || i == 18 || i == 27 || i == 29 || i == 30 || i == 31;
   endfunction

   // ----------------------------------------------------------------
   // Read answer monitor
   // ----------------------------------------------------------------
   always @(negedge ref_clk) begin
      if (mgmt_rd_valid === 1'b1) begin
         if (exp_d.size() == 0) chk_cnt(1, 0, "unexpected read answer");
         else chk_rd(mgmt_rd_data, mgmt_rd_hit, exp_d.pop_front(), exp_h.pop_front());
      end
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] d;
      logic strap0;
      int n;
      d = $random(seed);
      strap0 = d[0];
      do_reset(strap0);
      check_outs();
      do_rd(5'h00, dflt, 1'b1);
      idle(3);
      // Random control words with random negotiation results
      for (int i = 0; i < 12; i++) begin
         d = $random(seed);
         d[15] = 1'b0;
         {an_result_speed_100, an_result_full_duplex} = 2'($random(seed));
         n = restart_cnt;
         do_wr(5'h00, d);
         idle(4);
         ctrl_exp = d & 16'h7980;
         check_outs();
         chk_cnt(restart_cnt - n, int'(d[9]), "restart pulses");
         do_rd(5'h00, ctrl_exp, 1'b1);
      end
      // Completion flag against power down and restart
      do_wr(5'h00, 16'h1000);
      idle(3);
      pulse_done();
      idle(2);
      do_rd(5'h01, 16'h0020, 1'b1);
      do_wr(5'h00, 16'h1800);
      idle(3);
      do_rd(5'h01, 16'h0000, 1'b1);
      do_wr(5'h00, 16'h1000);
      idle(3);
      pulse_done();
      idle(2);
      do_rd(5'h01, 16'h0020, 1'b1);
      do_wr(5'h00, 16'h1200);
      idle(3);
      do_rd(5'h01, 16'h0000, 1'b1);
      idle(3);
      // Soft reset with other bits set, and a write dropped meanwhile
      n = srst_cnt;
      do_wr(5'h00, 16'hffff);
      idle(3);
      chk_bit(soft_reset_active, 1'b1, "soft reset active");
      do_rd(5'h00, 16'h8000 | dflt, 1'b1);
      do_wr(5'h00, 16'h4000);
      idle(1);
      for (int k = 0; k < 20 && soft_reset_active === 1'b1; k++) @(negedge ref_clk);
      chk_cnt(srst_cnt - n, 10, "soft reset cycles");
      ctrl_exp = dflt;
      check_outs();
      do_rd(5'h00, dflt, 1'b1);
      idle(3);
      // Every index but 0 written, then all read back to back
      for (int k = 1; k < 32; k++) do_wr(5'(k), 16'hffff);
      idle(2);
      for (int k = 0; k < 32; k++) do_rd(5'(k), (k == 0) ? dflt : 16'h0000, is_dec(k));
      idle(4);
      // Clean soft reset write, then two restart writes back to back
      n = srst_cnt;
      do_wr(5'h00, 16'h8000);
      idle(12);
      chk_cnt(srst_cnt - n, 10, "clean soft reset cycles");
      n = restart_cnt;
      do_wr(5'h00, 16'h1200);
      do_wr(5'h00, 16'h1200);
      idle(3);
      chk_cnt(restart_cnt - n, 2, "back to back restarts");
      // Second reset in mid-run with the other strap level
      do_wr(5'h00, 16'h4180);
      idle(1);
      do_reset(~strap0);
      check_outs();
      do_rd(5'h00, dflt, 1'b1);
      idle(4);
      chk_cnt(exp_d.size(), 0, "reads left unanswered");
      close_out();
   end
endmodule
